// >>> rtl/afe_control_register_bank.sv
// Control register bank of the analog front end, written and read through serial control frames
//
// Overview of operation
// [RULE1] Front-end enable runs filters and analog clocks
// [RULE2] Select bit chooses secondary or primary driver
// [RULE3] Two independent transmit boost bits
// [RULE4] Transmit disable floats both driver pairs
// [RULE5] Receive gain field decodes 6/9/12/0 dB
// [RULE6] Extra receive gain bit adds 20 dB
// [RULE7] Test modes only while test enable set; TEST_O passes the test fields on without gating by test_mode_enable
// [RULE8] Digital loopback ties transmit filter to receive
// [RULE9] Analog loopback ties transmitter to receiver
// [RULE10] Remote loopback ties receiver to transmitter
// [RULE11] Clock output enable drives clock pin
// [RULE12] Host sets chain sync before clock out
// [RULE13] Bias pull biases receive inputs for test
// [RULE14] Slot bit places control frame quarter/half
// [RULE15] Hardware frame control redefines input bit 0
// [RULE16] Version nibble readable in version register
// [RULE17] Chain sync enable drives delayed frame sync
// [RULE18] Host writes reserved bits only with defaults
// [RULE19] Writes to unused bits are ignored
// [RULE20] Reset loads pin value and mode ones
// [RULE21] Mode bit zero drives pin from value
// [RULE22] Pin value read returns sensed levels
// [RULE23] Control word: flag, address, data; write answers zero
// [RULE24] Unimplemented addresses ignore writes
// [RULE25] Reset loads every register default
`timescale 1ns/10ps
`default_nettype none
module afe_control_register_bank #(
	parameter logic [3:0] CHIP_VERSION = 4'h3 // Arbitrary value
) (
	input wire logic CLOCK_I, // System clock
	input wire logic RESET_I, // Synchronous reset, active high
	input wire logic LINK_CLOCK_I, // Serial link clock
	input wire logic FRAME_SYNC_I, // Frame start, link domain
	input wire logic CONTROL_FRAME_I, // Frame starting is a control frame
	input wire logic SERIAL_DATA_IN_I, // Serial input bit
	input wire logic [15:0] RX_WORD_I, // Receive code word for data frames
	output logic SERIAL_DATA_OUT_O, // Serial output bit
	output logic [15:0] TX_WORD_O, // Transmit code word of last data frame
	output logic TX_WORD_VALID_O, // One-cycle strobe with the transmit word
	output logic CONTROL_FRAME_REQUEST_O, // One-cycle software control frame request
	input wire logic [7:0] GPIO_I, // Sensed pin levels
	output logic [7:0] GPIO_O, // Pin output values
	output logic [7:0] GPIO_OE_O, // Pin output enables
	input wire logic SYNTH_LOCKED_I, // Synthesizer lock indication
	output afe_regs_pkg::front_end_type FRONT_END_O, // Front end control fields
	output afe_regs_pkg::test_type TEST_O, // Loopback and test fields
	output afe_regs_pkg::synth_type SYNTH_O, // Synthesizer registers
	output logic FRONT_END_CLOCK_EN_O, // Filter and analog clock enable
	output logic PRIMARY_TX_EN_O, // Primary transmit pair driven
	output logic SECONDARY_TX_EN_O, // Secondary transmit pair driven
	output logic [5:0] RX_GAIN_DB_O, // Total receive gain in dB
	output logic CLOCK_OUT_PIN_OE_O, // Clock output pin enable
	output logic CHAINED_FRAME_SYNC_OE_O // Delayed frame sync pin enable
);
	import afe_regs_pkg::*;
	typedef enum logic {LINK_IDLE, LINK_SHIFT} link_state_type;
	// Receive gain decode driving the gain output
	function automatic logic [5:0] rx_gain_db(input front_end_type fe);
		logic [5:0] base;
		case (fe.rx_gain_select)
			2'b00: base = RX_GAIN_SEL0_DB;
			2'b01: base = RX_GAIN_SEL1_DB;
			2'b10: base = RX_GAIN_SEL2_DB;
			default: base = RX_GAIN_SEL3_DB;
		endcase
		return fe.rx_extra_gain_enable ? 6'(base + RX_EXTRA_GAIN_DB) : base;
	endfunction
	// System domain registers
	front_end_type front_end_reg, front_end_next; // Front end control
	test_type test_reg, test_next; // Loopback and test
	logic [7:0] pin_value_reg, pin_value_next; // Pin output values
	logic [7:0] pin_mode_reg, pin_mode_next; // One means input
	logic chain_enable_reg, chain_enable_next; // Delayed frame sync enable
	synth_type synth_reg, synth_next; // Synthesizer registers
	logic [7:0] rdata_reg, rdata_next; // Answer byte to the link
	logic ack_tog_reg, ack_tog_next; // Answer ready toggle
	// Synchronisers into the system domain
	logic [7:0] gpio_meta_reg, gpio_sync_reg; // Pin level stages
	logic lock_meta_reg, lock_sync_reg; // Lock level stages
	logic req_meta_reg, req_sync_reg, req_seen_reg; // Request toggle stages
	// Link domain registers
	link_state_type link_state_reg, link_state_next; // Frame shifter state
	logic [3:0] bit_cnt_reg, bit_cnt_next; // Bit index in frame
	logic is_ctrl_reg, is_ctrl_next; // Current frame is control
	logic [15:0] shift_in_reg, shift_in_next; // Input shifter
	logic [15:0] shift_out_reg, shift_out_next; // Output shifter
	control_word_type ctl_word_reg, ctl_word_next; // Held control word
	logic req_tog_reg, req_tog_next; // Control word ready toggle
	logic [7:0] reply_reg, reply_next; // Answer for next control frame
	logic [15:0] tx_word_reg, tx_word_next; // Transmit word out
	logic tx_valid_reg, tx_valid_next; // Transmit strobe
	logic frame_req_reg, frame_req_next; // Control frame request strobe
	// Synchronisers into the link domain
	logic rst_meta_reg, link_rst_reg; // Reset stages
	logic hc_meta_reg, hc_sync_reg; // Hardware frame control stages
	logic ack_meta_reg, ack_sync_reg, ack_seen_reg; // Answer toggle stages
	// Request pulse and taken word
	logic req_pulse; // New control word in system domain
	control_word_type cw; // Control word being served
	logic [15:0] word_in; // Complete frame word
	// Level and toggle synchronisers in the system domain
	always_ff @(posedge CLOCK_I) begin
		gpio_meta_reg <= GPIO_I;
		gpio_sync_reg <= gpio_meta_reg;
		lock_meta_reg <= SYNTH_LOCKED_I;
		lock_sync_reg <= lock_meta_reg;
		req_meta_reg <= req_tog_reg;
		req_sync_reg <= req_meta_reg;
		if (RESET_I) begin
			req_seen_reg <= 1'b0;
		end else begin
			req_seen_reg <= req_sync_reg;
		end
	end
	assign req_pulse = req_sync_reg ^ req_seen_reg;
	// Word is stable: link holds it until the next control frame ends
	assign cw = ctl_word_reg;
	// Register write and read service
	always_comb begin
		front_end_next = front_end_reg;
		test_next = test_reg;
		pin_value_next = pin_value_reg;
		pin_mode_next = pin_mode_reg;
		chain_enable_next = chain_enable_reg;
		synth_next = synth_reg;
		rdata_next = rdata_reg;
		ack_tog_next = ack_tog_reg;
		if (req_pulse) begin
			ack_tog_next = ~ack_tog_reg;
			// [RULE23] write answers zero
			rdata_next = 8'h00;
			if (!cw.read_flag) begin
				// [RULE24] [RULE19] masked address decode
				case (cw.addr)
					ADDR_FRONT_END: front_end_next = cw.data;
					ADDR_LOOPBACK_TEST: test_next = cw.data;
					ADDR_IO_PIN_VALUE: pin_value_next = cw.data;
					ADDR_IO_PIN_MODE: pin_mode_next = cw.data;
					ADDR_VERSION_CHAIN: chain_enable_next = cw.data[CHAIN_ENABLE_BIT];
					ADDR_PRESCALER_SEQ: synth_next.prescaler_sequence = cw.data;
					ADDR_PRESCALER_DIV: synth_next.prescaler_divisor_reset = cw.data;
					ADDR_PUMP_VCO: synth_next.charge_pump_vco_gain = cw.data & WMASK_PUMP_VCO;
					ADDR_FEEDBACK_DIV: synth_next.feedback_divisor = cw.data & WMASK_FEEDBACK_DIV;
					ADDR_FEEDBACK_SEQ: synth_next.feedback_sequence = cw.data;
					ADDR_XTAL_BIAS: synth_next.crystal_bias_feedback_reset =
						(cw.data & WMASK_XTAL_BIAS) | (RST_XTAL_BIAS & ~WMASK_XTAL_BIAS);
					ADDR_SYNTH_LOCK: synth_next.synth_lock_control = cw.data & WMASK_SYNTH_LOCK;
					default: ;
				endcase
			end else begin
				// [RULE23] read answers register contents
				case (cw.addr)
					ADDR_FRONT_END: rdata_next = front_end_reg;
					ADDR_LOOPBACK_TEST: rdata_next = test_reg;
					// [RULE22] sensed pin levels
					ADDR_IO_PIN_VALUE: rdata_next = gpio_sync_reg;
					ADDR_IO_PIN_MODE: rdata_next = pin_mode_reg;
					// [RULE16] version nibble
					ADDR_VERSION_CHAIN: rdata_next = {CHIP_VERSION, chain_enable_reg, 3'b000};
					ADDR_PRESCALER_SEQ: rdata_next = synth_reg.prescaler_sequence;
					ADDR_PRESCALER_DIV: rdata_next = synth_reg.prescaler_divisor_reset;
					ADDR_PUMP_VCO: rdata_next = synth_reg.charge_pump_vco_gain;
					ADDR_FEEDBACK_DIV: rdata_next = synth_reg.feedback_divisor;
					ADDR_FEEDBACK_SEQ: rdata_next = synth_reg.feedback_sequence;
					ADDR_XTAL_BIAS: rdata_next = synth_reg.crystal_bias_feedback_reset;
					ADDR_SYNTH_LOCK: begin
						rdata_next = synth_reg.synth_lock_control;
						rdata_next[LOCK_DETECT_BIT] = lock_sync_reg;
					end
					default: rdata_next = 8'h00;
				endcase
			end
		end
		// Force-VCO drops with synthesizer power down or front end off
		if (synth_next.synth_lock_control[SYNTH_POWERDOWN_BIT] || !front_end_next.front_end_enable) begin
			synth_next.synth_lock_control[FORCE_VCO_BIT] = 1'b0;
		end
	end

	// System domain register stage
	always_ff @(posedge CLOCK_I) begin
		if (RESET_I) begin
			// [RULE25] [RULE20] defaults at reset
			front_end_reg <= RST_FRONT_END;
			test_reg <= RST_LOOPBACK_TEST;
			pin_value_reg <= RST_IO_PIN_VALUE;
			pin_mode_reg <= RST_IO_PIN_MODE;
			chain_enable_reg <= RST_CHAIN_ENABLE[0];
			synth_reg <= {RST_PRESCALER_SEQ, RST_PRESCALER_DIV, RST_PUMP_VCO, RST_FEEDBACK_DIV,
				RST_FEEDBACK_SEQ, RST_XTAL_BIAS, RST_SYNTH_LOCK};
			rdata_reg <= 8'h00;
			ack_tog_reg <= 1'b0;
		end else begin
			front_end_reg <= front_end_next;
			test_reg <= test_next;
			pin_value_reg <= pin_value_next;
			pin_mode_reg <= pin_mode_next;
			chain_enable_reg <= chain_enable_next;
			synth_reg <= synth_next;
			rdata_reg <= rdata_next;
			ack_tog_reg <= ack_tog_next;
		end
	end

	// Controls to the analog and pin logic
	assign FRONT_END_O = front_end_reg;
	// [RULE7] [RULE8] [RULE9] [RULE10] [RULE13] [RULE14] test fields
	assign TEST_O = test_reg;
	assign SYNTH_O = synth_reg;
	// [RULE1] clocks gated with front end
	assign FRONT_END_CLOCK_EN_O = front_end_reg.front_end_enable;
	// [RULE2] [RULE4] driver pair selection
	assign PRIMARY_TX_EN_O = !front_end_reg.tx_driver_disable && !front_end_reg.secondary_driver_select;
	assign SECONDARY_TX_EN_O = !front_end_reg.tx_driver_disable && front_end_reg.secondary_driver_select;
	// [RULE5] [RULE6] receive gain
	assign RX_GAIN_DB_O = rx_gain_db(front_end_reg);
	// [RULE11] clock output pin
	assign CLOCK_OUT_PIN_OE_O = test_reg.clock_out_enable;
	// [RULE17] delayed frame sync pin
	assign CHAINED_FRAME_SYNC_OE_O = chain_enable_reg;
	// [RULE21] pin drive
	assign GPIO_O = pin_value_reg;
	assign GPIO_OE_O = ~pin_mode_reg;

	// Synchronisers into the link domain
	always_ff @(posedge LINK_CLOCK_I) begin
		rst_meta_reg <= RESET_I;
		link_rst_reg <= rst_meta_reg;
		hc_meta_reg <= test_reg.hardware_frame_control;
		hc_sync_reg <= hc_meta_reg;
		ack_meta_reg <= ack_tog_reg;
		ack_sync_reg <= ack_meta_reg;
	end
	assign word_in = {shift_in_reg[14:0], SERIAL_DATA_IN_I};
	// Frame shifter next state
	always_comb begin
		link_state_next = link_state_reg;
		bit_cnt_next = bit_cnt_reg;
		is_ctrl_next = is_ctrl_reg;
		shift_in_next = shift_in_reg;
		shift_out_next = shift_out_reg;
		ctl_word_next = ctl_word_reg;
		req_tog_next = req_tog_reg;
		reply_next = reply_reg;
		tx_word_next = tx_word_reg;
		tx_valid_next = 1'b0;
		frame_req_next = 1'b0;
		// Answer from the system domain waits for the next control frame
		if (ack_sync_reg != ack_seen_reg) begin
			reply_next = rdata_reg;
		end
		case (link_state_reg)
			LINK_IDLE: begin
				if (FRAME_SYNC_I) begin
					link_state_next = LINK_SHIFT;
					bit_cnt_next = 4'd0;
					is_ctrl_next = CONTROL_FRAME_I;
					shift_out_next = CONTROL_FRAME_I ? {8'h00, reply_reg} : RX_WORD_I;
				end
			end
			LINK_SHIFT: begin
				shift_in_next = word_in;
				shift_out_next = {shift_out_reg[14:0], 1'b0};
				bit_cnt_next = 4'(bit_cnt_reg + 4'd1);
				if (bit_cnt_reg == FRAME_LAST_BIT) begin
					link_state_next = LINK_IDLE;
					if (is_ctrl_reg) begin
						// [RULE23] control word handed over
						ctl_word_next = word_in;
						req_tog_next = ~req_tog_reg;
					end else begin
						// [RULE15] bit 0 data or request
						tx_word_next = hc_sync_reg ? word_in : {word_in[15:1], 1'b0};
						tx_valid_next = 1'b1;
						frame_req_next = !hc_sync_reg && word_in[0];
					end
				end
			end
			default: link_state_next = LINK_IDLE;
		endcase
	end

	// Frame shifter register stage
	always_ff @(posedge LINK_CLOCK_I) begin
		if (link_rst_reg) begin
			link_state_reg <= LINK_IDLE;
			bit_cnt_reg <= 4'd0;
			is_ctrl_reg <= 1'b0;
			shift_in_reg <= 16'h0000;
			shift_out_reg <= 16'h0000;
			ctl_word_reg <= 16'h0000;
			req_tog_reg <= 1'b0;
			reply_reg <= 8'h00;
			tx_word_reg <= 16'h0000;
			tx_valid_reg <= 1'b0;
			frame_req_reg <= 1'b0;
			ack_seen_reg <= 1'b0;
		end else begin
			link_state_reg <= link_state_next;
			bit_cnt_reg <= bit_cnt_next;
			is_ctrl_reg <= is_ctrl_next;
			shift_in_reg <= shift_in_next;
			shift_out_reg <= shift_out_next;
			ctl_word_reg <= ctl_word_next;
			req_tog_reg <= req_tog_next;
			reply_reg <= reply_next;
			tx_word_reg <= tx_word_next;
			tx_valid_reg <= tx_valid_next;
			frame_req_reg <= frame_req_next;
			ack_seen_reg <= ack_sync_reg;
		end
	end

	assign SERIAL_DATA_OUT_O = shift_out_reg[15];
	assign TX_WORD_O = tx_word_reg;
	assign TX_WORD_VALID_O = tx_valid_reg;
	assign CONTROL_FRAME_REQUEST_O = frame_req_reg;
	// Checks on the system domain
	sequence s_write_taken(logic [6:0] a);
		req_pulse && !cw.read_flag && cw.addr == a;
	endsequence
	a_front_end_gate: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // [RULE1]
		s_write_taken(ADDR_FRONT_END) |=> FRONT_END_CLOCK_EN_O == $past(cw.data[7]))
		else $error("front end clock enable mismatch");
	a_driver_pair_select: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // [RULE2]
		s_write_taken(ADDR_FRONT_END) ##0 !cw.data[3] |=> SECONDARY_TX_EN_O == $past(cw.data[6])
		&& PRIMARY_TX_EN_O == !$past(cw.data[6]))
		else $error("transmit pair selection wrong");
	a_driver_float: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // [RULE4]
		s_write_taken(ADDR_FRONT_END) ##0 cw.data[3] |=> !PRIMARY_TX_EN_O && !SECONDARY_TX_EN_O)
		else $error("transmit pairs driven while disabled");
	a_rx_gain_decode: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // [RULE5]
		s_write_taken(ADDR_FRONT_END) ##0 cw.data[2:0] == 3'b101 |=> RX_GAIN_DB_O == 6'd32)
		else $error("receive gain decode wrong");
	a_clock_out_pin: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // [RULE11]
		s_write_taken(ADDR_LOOPBACK_TEST) |=> CLOCK_OUT_PIN_OE_O == $past(cw.data[3]))
		else $error("clock output enable not following write");
	a_chain_sync_pin: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // [RULE17]
		s_write_taken(ADDR_VERSION_CHAIN) |=> CHAINED_FRAME_SYNC_OE_O == $past(cw.data[3]))
		else $error("chain sync enable not following write");
	a_pin_reset_input: assert property (@(posedge CLOCK_I) // [RULE20]
		$fell(RESET_I) |-> GPIO_OE_O == 8'h00 && GPIO_O == 8'hff)
		else $error("pins not inputs after reset");
	a_pin_drive_mode: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // [RULE21]
		s_write_taken(ADDR_IO_PIN_MODE) |=> GPIO_OE_O == ~$past(cw.data))
		else $error("pin enables not following mode write");
	a_pin_read_sensed: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // [RULE22]
		req_pulse && cw.read_flag && cw.addr == ADDR_IO_PIN_VALUE |=> rdata_reg == $past(gpio_sync_reg))
		else $error("pin value read not sensed levels");
	a_write_answer_zero: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // [RULE23]
		req_pulse && !cw.read_flag |=> rdata_reg == 8'h00 ##0 $changed(ack_tog_reg))
		else $error("write answer not zero");
	a_unmapped_ignored: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // [RULE24]
		req_pulse && cw.addr > ADDR_SYNTH_LOCK |=> $stable(front_end_reg) && $stable(test_reg)
		&& $stable(pin_value_reg) && $stable(pin_mode_reg) && $stable(synth_reg))
		else $error("unmapped write changed a register");
	// Check on the link domain
	a_request_bit: assert property (@(posedge LINK_CLOCK_I) disable iff (link_rst_reg) // [RULE15]
		TX_WORD_VALID_O |-> TX_WORD_O[0] == 1'b0 || hc_sync_reg || $past(hc_sync_reg))
		else $error("bit 0 not forced under software frame control");
endmodule // afe_control_register_bank
`default_nettype wire

// >>> rtl/afe_regs_pkg.sv
// Package: register map, field layouts, reset values and carrier types of the control bank
package afe_regs_pkg;
	// Register addresses (7-bit control word address)
	localparam logic [6:0] ADDR_FRONT_END = 7'h00;
	localparam logic [6:0] ADDR_LOOPBACK_TEST = 7'h01;
	localparam logic [6:0] ADDR_IO_PIN_VALUE = 7'h02;
	localparam logic [6:0] ADDR_IO_PIN_MODE = 7'h03;
	localparam logic [6:0] ADDR_RESERVED_04 = 7'h04;
	localparam logic [6:0] ADDR_RESERVED_05 = 7'h05;
	localparam logic [6:0] ADDR_VERSION_CHAIN = 7'h06;
	localparam logic [6:0] ADDR_RESERVED_07 = 7'h07;
	localparam logic [6:0] ADDR_PRESCALER_SEQ = 7'h08;
	localparam logic [6:0] ADDR_PRESCALER_DIV = 7'h09;
	localparam logic [6:0] ADDR_PUMP_VCO = 7'h0a;
	localparam logic [6:0] ADDR_FEEDBACK_DIV = 7'h0b;
	localparam logic [6:0] ADDR_FEEDBACK_SEQ = 7'h0c;
	localparam logic [6:0] ADDR_XTAL_BIAS = 7'h0d;
	localparam logic [6:0] ADDR_SYNTH_LOCK = 7'h0e;
	// Reset values
	localparam logic [7:0] RST_FRONT_END = 8'h08;
	localparam logic [7:0] RST_LOOPBACK_TEST = 8'h00;
	localparam logic [7:0] RST_IO_PIN_VALUE = 8'hff;
	localparam logic [7:0] RST_IO_PIN_MODE = 8'hff;
	localparam logic [7:0] RST_PRESCALER_SEQ = 8'h00;
	localparam logic [7:0] RST_PRESCALER_DIV = 8'h0a;
	localparam logic [7:0] RST_PUMP_VCO = 8'h22;
	localparam logic [7:0] RST_FEEDBACK_DIV = 8'h12;
	localparam logic [7:0] RST_FEEDBACK_SEQ = 8'h00;
	localparam logic [7:0] RST_XTAL_BIAS = 8'hc0;
	localparam logic [7:0] RST_SYNTH_LOCK = 8'h00;
	localparam logic [3:0] RST_CHAIN_ENABLE = 4'h0;
	// Writable bit masks; unused and reserved bits keep their default
	localparam logic [7:0] WMASK_PUMP_VCO = 8'hf7;
	localparam logic [7:0] WMASK_FEEDBACK_DIV = 8'h7f;
	localparam logic [7:0] WMASK_XTAL_BIAS = 8'hc7;
	localparam logic [7:0] WMASK_SYNTH_LOCK = 8'hc0;
	// Field positions
	localparam int VERSION_LSB = 4;
	localparam int CHAIN_ENABLE_BIT = 3;
	localparam int FORCE_VCO_BIT = 7;
	localparam int SYNTH_POWERDOWN_BIT = 6;
	localparam int LOCK_DETECT_BIT = 5;
	// Receive gain figures in dB
	localparam logic [5:0] RX_GAIN_SEL0_DB = 6'd6;
	localparam logic [5:0] RX_GAIN_SEL1_DB = 6'd9;
	localparam logic [5:0] RX_GAIN_SEL2_DB = 6'd12;
	localparam logic [5:0] RX_GAIN_SEL3_DB = 6'd0;
	localparam logic [5:0] RX_EXTRA_GAIN_DB = 6'd20;
	// Index of the last bit of a 16-bit serial frame
	localparam logic [3:0] FRAME_LAST_BIT = 4'd15;

	// Front end control register layout
	typedef struct packed {
		logic front_end_enable;
		logic secondary_driver_select;
		logic tx_boost_high;
		logic tx_boost_low;
		logic tx_driver_disable;
		logic [1:0] rx_gain_select;
		logic rx_extra_gain_enable;
	} front_end_type;
	// Loopback and test control register layout
	typedef struct packed {
		logic test_mode_enable;
		logic digital_loopback;
		logic analog_loopback;
		logic remote_loopback;
		logic clock_out_enable;
		logic rx_bias_pull;
		logic control_slot_position;
		logic hardware_frame_control;
	} test_type;
	// Clock synthesizer registers, passed on as a group
	typedef struct packed {
		logic [7:0] prescaler_sequence;
		logic [7:0] prescaler_divisor_reset;
		logic [7:0] charge_pump_vco_gain;
		logic [7:0] feedback_divisor;
		logic [7:0] feedback_sequence;
		logic [7:0] crystal_bias_feedback_reset;
		logic [7:0] synth_lock_control;
	} synth_type;
	// Control word on the serial input
	typedef struct packed {
		logic read_flag;
		logic [6:0] addr;
		logic [7:0] data;
	} control_word_type;
endpackage

// >>> bench/serial_host.sv
// Host side model of the serial port: frames control and data words
`timescale 1ns/10ps
`default_nettype none
module serial_host (
	input wire logic link_clock_i, // Link clock, runs free
	input wire logic serial_data_out_i, // Device serial output
	output logic frame_sync_o, // Frame start pulse
	output logic control_frame_o, // Frame kind, high for control
	output logic serial_data_in_o // Serial word to the device
);
	// Idle levels at time zero
	initial begin
		frame_sync_o = 1'b0;
		control_frame_o = 1'b0;
		serial_data_in_o = 1'b0;
	end
	// One frame, most significant bit first, then a gap for the answer to cross
	// word layout, top bit first
	task automatic xfer(input logic ctl, input logic [15:0] word, output logic [15:0] resp);
		@(posedge link_clock_i);
		frame_sync_o <= 1'b1;
		control_frame_o <= ctl;
		for (int i = 15; i >= 0; i--) begin
			@(posedge link_clock_i);
			frame_sync_o <= 1'b0;
			serial_data_in_o <= word[i];
			@(negedge link_clock_i);
			resp[i] = serial_data_out_i;
		end
		@(posedge link_clock_i);
		// Released line shows the inverse of its last value
		serial_data_in_o <= ~word[0];
		control_frame_o <= ~ctl;
		repeat (10) @(posedge link_clock_i);
	endtask
endmodule // serial_host
`default_nettype wire

// >>> bench/test_afe_control_register_bank.sv
// Self-checking bench of the control register bank over the serial host port
`timescale 1ns/10ps
`default_nettype none
module test_afe_control_register_bank;
	import afe_regs_pkg::*;
	localparam logic [3:0] chip_ver = 4'ha; // Arbitrary value
	logic clock, reset, link_clock, frame_sync, control_frame, serial_data_in, serial_data_out, synth_locked;
	logic tx_valid, ctl_request, fe_clk_en, pri_en, sec_en, clk_oe, fsd_oe;
	logic [15:0] rx_word, tx_word, resp;
	logic [7:0] gpio_in, gpio_out, gpio_oe, d;
	logic [5:0] rx_db;
	front_end_type front_end;
	test_type test_bits;
	synth_type synth;
	int failures = 0;
	int tests_run = 0;
	int valid_count = 0;
	int request_count = 0;
	logic [5:0] gain_tab [4] = '{RX_GAIN_SEL0_DB, RX_GAIN_SEL1_DB, RX_GAIN_SEL2_DB, RX_GAIN_SEL3_DB};
	logic [7:0] dflt [16] = '{RST_FRONT_END, RST_LOOPBACK_TEST, 8'h5a, RST_IO_PIN_MODE, 8'h00,
		8'h00, {chip_ver, 4'h0}, 8'h00, RST_PRESCALER_SEQ, RST_PRESCALER_DIV, RST_PUMP_VCO,
		RST_FEEDBACK_DIV, RST_FEEDBACK_SEQ, RST_XTAL_BIAS, 8'h20, 8'h00};
	// Address, written data, expected read back
	logic [23:0] wtab [12] = '{{8'h06, 8'h08, chip_ver, 4'h8}, 24'h01ffff, 24'h00ffff,
		24'h08a5a5, 24'h095c5c, 24'h0af7f7, 24'h0bff7f, 24'h0c3c3c, 24'h0dcfc7, 24'h0eff60,
		24'h040000, 24'h0f7700};
	afe_control_register_bank #(.CHIP_VERSION(chip_ver)) DUT (.CLOCK_I(clock), .RESET_I(reset),
		.LINK_CLOCK_I(link_clock), .FRAME_SYNC_I(frame_sync), .CONTROL_FRAME_I(control_frame),
		.SERIAL_DATA_IN_I(serial_data_in), .RX_WORD_I(rx_word), .SERIAL_DATA_OUT_O(serial_data_out),
		.TX_WORD_O(tx_word), .TX_WORD_VALID_O(tx_valid), .CONTROL_FRAME_REQUEST_O(ctl_request),
		.GPIO_I(gpio_in), .GPIO_O(gpio_out), .GPIO_OE_O(gpio_oe), .SYNTH_LOCKED_I(synth_locked),
		.FRONT_END_O(front_end), .TEST_O(test_bits), .SYNTH_O(synth),
		.FRONT_END_CLOCK_EN_O(fe_clk_en), .PRIMARY_TX_EN_O(pri_en), .SECONDARY_TX_EN_O(sec_en),
		.RX_GAIN_DB_O(rx_db), .CLOCK_OUT_PIN_OE_O(clk_oe), .CHAINED_FRAME_SYNC_OE_O(fsd_oe));
	serial_host host (.link_clock_i(link_clock), .serial_data_out_i(serial_data_out),
		.frame_sync_o(frame_sync), .control_frame_o(control_frame), .serial_data_in_o(serial_data_in));
	// System clock, 25 ns
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// Link clock, 80 ns, offset in phase
	initial begin
		link_clock = 1'b0;
		#7;
		forever #40 link_clock = ~link_clock;
	end
	// Count word strobes, one per link cycle
	always @(negedge link_clock) begin
		if (tx_valid === 1'b1)
			valid_count++;
		if (ctl_request === 1'b1)
			request_count++;
	end
	// Compare and report
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		tests_run++;
		if (seen !== want) begin
			failures++;
			$display("BAD at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	// Write, then confirm the write answer of zero
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		host.xfer(1'b1, {1'b0, a, v}, resp);
		host.xfer(1'b1, {1'b1, a, 8'h00}, resp);
		check(resp, 16'h0000);
	endtask
	// Read: answer comes back in the next control frame
	task automatic rc(input logic [6:0] a, input logic [7:0] want);
		host.xfer(1'b1, {1'b1, a, 8'h00}, resp);
		host.xfer(1'b1, {1'b1, a, 8'h00}, resp);
		check(resp, {8'h00, want});
	endtask
	// Counts, verdict and end of run
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Watchdog against a hang
	initial begin
		#2000000;
		failures++;
		end_sim();
	end
	// Main sequence
	initial begin
		reset = 1'b1;
		rx_word = 16'hc3a5;
		gpio_in = 8'h5a;
		synth_locked = 1'b1;
		repeat (16) @(posedge clock);
		reset <= 1'b0;
		repeat (16) @(posedge clock);
		check(16'(gpio_oe), 16'h0000);
		check(16'(gpio_out), 16'h00ff);
		for (int a = 0; a < 16; a++)
			rc(a[6:0], dflt[a]);
		// chain sync before clock out, reserved bits kept default
		foreach (wtab[i]) begin
			wr(wtab[i][22:16], wtab[i][15:8]);
			rc(wtab[i][22:16], wtab[i][7:0]);
		end
		check(16'(clk_oe), 16'h0001);
		check(16'(fsd_oe), 16'h0001);
		check(16'(test_bits), 16'h00ff);
		check(16'({pri_en, sec_en, fe_clk_en}), 16'h0001);
		check(synth[55:40], 16'ha55c);
		check(synth[39:24], 16'hf77f);
		check(synth[23:8], 16'h3cc7);
		check(16'(synth[7:0]), 16'h0040);
		for (int i = 0; i < 32; i++) begin
			d = {1'b1, i[4], i[0], ~i[0], i[3], i[2:0]};
			wr(ADDR_FRONT_END, d);
			check(16'(front_end), 16'(d));
			check(16'({pri_en, sec_en}), 16'({~i[3] & ~i[4], ~i[3] & i[4]}));
			check(16'(rx_db), 16'(gain_tab[i[2:1]] + (i[0] ? RX_EXTRA_GAIN_DB : 6'd0)));
		end
		wr(ADDR_FRONT_END, 8'h00);
		check(16'(fe_clk_en), 16'h0000);
		wr(ADDR_IO_PIN_MODE, 8'h0f);
		wr(ADDR_IO_PIN_VALUE, 8'ha5);
		check(16'(gpio_oe), 16'h00f0);
		check(16'(gpio_out), 16'h00a5);
		@(posedge clock);
		gpio_in <= 8'h3c;
		rc(ADDR_IO_PIN_VALUE, 8'h3c);
		host.xfer(1'b0, 16'h1235, resp);
		check(resp, rx_word);
		check(tx_word, 16'h1235);
		wr(ADDR_LOOPBACK_TEST, 8'h00);
		host.xfer(1'b0, 16'h1235, resp);
		check(tx_word, 16'h1234);
		check(16'(valid_count), 16'h0002);
		check(16'(request_count), 16'h0001);
		// Second reset in mid-run brings every default back
		@(posedge clock);
		reset <= 1'b1;
		repeat (16) @(posedge clock);
		reset <= 1'b0;
		repeat (16) @(posedge clock);
		check(16'(gpio_oe), 16'h0000);
		check(synth[55:40], {RST_PRESCALER_SEQ, RST_PRESCALER_DIV});
		rc(ADDR_FRONT_END, RST_FRONT_END);
		end_sim();
	end
endmodule // test_afe_control_register_bank
`default_nettype wire
